// ---- verilog/rapt_pkg.sv ----
// shared constants, command codes and register map of the auto precharge timing link
package rapt_pkg;
  // clock period and minimum times in picoseconds
  localparam int TCK_PS = 100000;
  localparam int TRAS_PS = 40000;
  localparam int TRTP_PS = 7500;
  localparam int TRP_PS = 15000;
  // least times rounded up to whole clocks
  localparam logic [7:0] TRAS_CYC = 8'((TRAS_PS + TCK_PS - 1) / TCK_PS);
  localparam logic [7:0] TRTP_CYC = 8'((TRTP_PS + TCK_PS - 1) / TCK_PS);
  localparam logic [7:0] TRP_CYC = 8'((TRP_PS + TCK_PS - 1) / TCK_PS);
  localparam logic [7:0] RTP_RP_CYC = 8'((TRTP_PS + TRP_PS + TCK_PS - 1) / TCK_PS);
  // fixed clock spacings
  localparam logic [7:0] PF_GAP_CYC = 8'h02;
  localparam logic [7:0] BL8_EXTRA = 8'h02;
  localparam logic [7:0] WR_EXTRA = 8'h02;
  localparam logic [7:0] PA_GAP_CYC = 8'h01;
  localparam logic [7:0] BL4_HALF = 8'h02;
  localparam logic [7:0] BL8_HALF = 8'h04;
  localparam int PIPE_LEN = 16;
  // link commands
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_PRE = 3'h4
  } rapt_cmd_t;
  // controller register offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  // field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BANK_LSB = 3;
  localparam int CMD_A10_BIT = 6;
  localparam int CMD_COL_LSB = 7;
  localparam int CMD_WDATA_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RVALID_BIT = 1;
  localparam int STAT_RDATA_LSB = 16;
  localparam int MODE_AL_LSB = 0;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_BL8_BIT = 8;
  // reset values
  localparam logic [2:0] AL_RST = 3'h0;
  localparam logic [2:0] CL_RST = 3'h3;
  localparam logic BL8_RST = 1'b0;
endpackage

// ---- verilog/rapt_if.sv ----
// link between controller and memory device: commands, data and strobes
`timescale 1ns/1ns
`default_nettype none
interface rapt_if;
  rapt_pkg::rapt_cmd_t cmd;
  logic [2:0] bank;
  logic a10;
  logic [2:0] col;
  logic [15:0] dq_dev;
  logic dq_dev_oe_n;
  logic [15:0] dq_ctl;
  logic dq_ctl_oe_n;
  logic ldqs;
  logic udqs;
  logic dqs_oe_n;
  logic [15:0] dq_bus;

  // resolved data wire level
  assign dq_bus = !dq_dev_oe_n ? dq_dev : (!dq_ctl_oe_n ? dq_ctl : 16'h0000);

  modport dev (
    input cmd, bank, a10, col, dq_bus,
    output dq_dev, dq_dev_oe_n, ldqs, udqs, dqs_oe_n
  );
  modport ctl (
    output cmd, bank, a10, col, dq_ctl, dq_ctl_oe_n,
    input dq_bus, ldqs, udqs, dqs_oe_n
  );
endinterface
`default_nettype wire

// ---- verilog/rapt_cnt.sv ----
// down counter that reports when a loaded spacing has run out
`timescale 1ns/1ns
`default_nettype none
module rapt_cnt (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // load and expiry
  input wire logic load,
  input wire logic [7:0] value,
  output logic done
);
  logic [7:0] count;

  // done in the cycle whose closing edge is value edges after the load edge
  assign done = (count <= 8'h01) && !load;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 8'h00;
    else if (load)
      count <= value;
    else if (count != 8'h00)
      count <= count - 8'h01;
  end
endmodule // rapt_cnt
`default_nettype wire

// ---- verilog/rapt_dev.sv ----
// device end: per-bank auto precharge timing and x16 read/write data path
`timescale 1ns/1ns
`default_nettype none
module rapt_dev (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // mode settings
  input wire logic [2:0] mode_al,
  input wire logic [2:0] mode_cl,
  input wire logic mode_bl8,
  // command and data link
  rapt_if.dev bus,
  // bank status
  output logic [7:0] bank_open,
  output logic [7:0] bank_closing,
  output logic timing_err
);
  import rapt_pkg::*;

  typedef enum logic [2:0] {
    DST_IDLE = 3'b001,
    DST_READ = 3'b010,
    DST_WRITE = 3'b100
  } rapt_dst_t;

  rapt_dst_t state;
  logic [15:0] mem [64];
  logic [PIPE_LEN-1:0] pipe_v;
  logic [PIPE_LEN-1:0] pipe_w;
  logic [5:0] pipe_a [PIPE_LEN];
  logic [3:0] beat;
  logic [5:0] base;
  logic [7:0] ap_pend;
  logic [7:0] ras_ok;
  logic [7:0] ap_ok;
  logic [7:0] rtp_ok;
  logic [7:0] rp_ok;
  logic [7:0] pchg_go;
  logic [7:0] act_hit;
  logic [7:0] rda_hit;

  // command decode
  wire is_act = bus.cmd == CMD_ACT;
  wire is_rd = bus.cmd == CMD_RD;
  wire is_wr = bus.cmd == CMD_WR;
  wire is_pre = bus.cmd == CMD_PRE;
  wire is_rda = is_rd && bus.a10;
  wire [2:0] cb = bus.bank;

  // mode derived delays
  wire [7:0] al8 = {5'h00, mode_al};
  wire [7:0] half_bl = mode_bl8 ? BL8_HALF : BL4_HALF;
  wire [3:0] bl_len = half_bl[3:0];
  wire [7:0] rl = al8 + {5'h00, mode_cl};
  wire [7:0] ap_delay = al8 + half_bl;
  wire [7:0] rtp_min = (TRTP_CYC > PF_GAP_CYC) ? TRTP_CYC : PF_GAP_CYC;
  wire [7:0] pf_last = al8 + (mode_bl8 ? BL8_EXTRA : 8'h00);
  wire [7:0] rtp_delay = pf_last + rtp_min;

  // per-bank timers
  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_bank
      wire sel = cb == 3'(b);
      assign act_hit[b] = is_act && sel;
      assign rda_hit[b] = is_rda && sel;
      rapt_cnt u_ras (
        .pclk(pclk),
        .presetn(presetn),
        .load(act_hit[b]),
        .value(TRAS_CYC),
        .done(ras_ok[b])
      );
      rapt_cnt u_ap (
        .pclk(pclk),
        .presetn(presetn),
        .load(rda_hit[b]),
        .value(ap_delay),
        .done(ap_ok[b])
      );
      rapt_cnt u_rtp (
        .pclk(pclk),
        .presetn(presetn),
        .load(rda_hit[b]),
        .value(rtp_delay),
        .done(rtp_ok[b])
      );
      rapt_cnt u_rp (
        .pclk(pclk),
        .presetn(presetn),
        .load(pchg_go[b]),
        .value(TRP_CYC),
        .done(rp_ok[b])
      );
      // auto precharge waits for every minimum, explicit one closes at once
      assign pchg_go[b] = (ap_pend[b] && ap_ok[b] && rtp_ok[b] && ras_ok[b])
        || (is_pre && sel && bank_open[b] && !ap_pend[b]);
    end
  endgenerate

  // bank state; a plain read leaves the row open
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bank_open <= 8'h00;
      ap_pend <= 8'h00;
      bank_closing <= 8'h00;
    end
    else
    begin
      bank_open <= (bank_open | act_hit) & ~pchg_go;
      ap_pend <= (ap_pend | rda_hit) & ~pchg_go;
      bank_closing <= pchg_go | (bank_closing & ~rp_ok);
    end
  end

  // misuse check, only the addressed bank matters
  wire err_now = (is_act && (bank_open[cb] || !rp_ok[cb]))
    || ((is_rd || is_wr) && (!bank_open[cb] || ap_pend[cb]));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timing_err <= 1'b0;
    else if (err_now)
      timing_err <= 1'b1;
  end

  // latency pipeline, shared tap serves read start and first write capture
  wire [3:0] tap = 4'(rl - 8'h01);
  wire tap_v = pipe_v[tap];
  wire tap_w = pipe_w[tap];
  wire [5:0] tap_a = pipe_a[tap];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pipe_v <= '0;
      pipe_w <= '0;
    end
    else
    begin
      pipe_v <= {pipe_v[PIPE_LEN-2:0], is_rd || is_wr};
      pipe_w <= {pipe_w[PIPE_LEN-2:0], is_wr};
    end
  end

  always_ff @(posedge pclk)
  begin
    pipe_a[0] <= {bus.bank, bus.col};
    for (int i = 1; i < PIPE_LEN; i++)
      pipe_a[i] <= pipe_a[i-1];
  end

  // data array
  wire in_burst = beat != bl_len;
  wire [5:0] cur_a = {base[5:3], base[2:0] + beat[2:0]};
  wire [5:0] mem_a = tap_v ? tap_a : cur_a;
  wire mem_we = (tap_v && tap_w) || (state == DST_WRITE && in_burst);

  always_ff @(posedge pclk)
  begin
    if (mem_we)
      mem[mem_a] <= bus.dq_bus;
  end

  // burst engine; a new burst at the tap takes over a finishing one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= DST_IDLE;
      beat <= 4'h0;
      base <= 6'h00;
      bus.dq_dev <= 16'h0000;
      bus.dq_dev_oe_n <= 1'b1;
      bus.dqs_oe_n <= 1'b1;
      bus.ldqs <= 1'b0;
      bus.udqs <= 1'b0;
    end
    else if (tap_v)
    begin
      state <= tap_w ? DST_WRITE : DST_READ;
      beat <= 4'h1;
      base <= tap_a;
      bus.dq_dev <= mem[mem_a];
      bus.dq_dev_oe_n <= tap_w;
      bus.dqs_oe_n <= tap_w;
      bus.ldqs <= !tap_w;
      bus.udqs <= !tap_w;
    end
    else
    begin
      unique case (state)
        DST_IDLE:
        begin
          beat <= 4'h0;
        end
        DST_READ:
        begin
          if (in_burst)
          begin
            bus.dq_dev <= mem[mem_a];
            beat <= beat + 4'h1;
            bus.ldqs <= !bus.ldqs;
            bus.udqs <= !bus.udqs;
          end
          else
          begin
            state <= DST_IDLE;
            bus.dq_dev_oe_n <= 1'b1;
            bus.dqs_oe_n <= 1'b1;
            bus.ldqs <= 1'b0;
            bus.udqs <= 1'b0;
          end
        end
        DST_WRITE:
        begin
          if (in_burst)
            beat <= beat + 4'h1;
          else
            state <= DST_IDLE;
        end
      endcase
    end
  end
endmodule // rapt_dev
`default_nettype wire

// ---- verilog/rapt_ctl.sv ----
// controller end: apb registers, command spacing and data capture
`timescale 1ns/1ns
`default_nettype none
module rapt_ctl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode settings for the device
  output logic [2:0] mode_al,
  output logic [2:0] mode_cl,
  output logic mode_bl8,
  // command and data link
  rapt_if.ctl bus
);
  import rapt_pkg::*;

  rapt_cmd_t op_q;
  logic busy;
  logic rvalid;
  logic cap_pend;
  logic wr_pend;
  logic [2:0] bank_q;
  logic [2:0] col_q;
  logic a10_q;
  logic [15:0] wdata_q;
  logic [15:0] wr_data;
  logic [15:0] rdata;
  logic [3:0] wbeat;
  logic [7:0] act_ok;
  logic [7:0] ras_ok;
  logic rd_ok;
  logic wr_ok;
  logic pa_ok;
  logic cap_ok;
  logic wrd_ok;
  logic [31:0] rd_mux;

  // apb decode
  wire acc = psel && penable && !pready;
  wire fin = psel && penable && pready;
  wire hit_cmd = paddr == ADDR_CMD;
  wire hit_stat = paddr == ADDR_STAT;
  wire hit_mode = paddr == ADDR_MODE;
  wire stall = acc && pwrite && hit_cmd && busy;
  wire cmd_wr = fin && pwrite && hit_cmd;
  wire mode_wr = fin && pwrite && hit_mode;
  // clear rvalid in the cycle whose status value goes out on prdata
  wire stat_rd = acc && !pwrite && hit_stat;

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (hit_stat)
    begin
      rd_mux[STAT_BUSY_BIT] = busy;
      rd_mux[STAT_RVALID_BIT] = rvalid;
      rd_mux[STAT_RDATA_LSB +: 16] = rdata;
    end
    else if (hit_mode)
    begin
      rd_mux[MODE_AL_LSB +: 3] = mode_al;
      rd_mux[MODE_CL_LSB +: 3] = mode_cl;
      rd_mux[MODE_BL8_BIT] = mode_bl8;
    end
  end

  // own command as seen by the device
  wire sent_act = bus.cmd == CMD_ACT;
  wire sent_rd = bus.cmd == CMD_RD;
  wire sent_wr = bus.cmd == CMD_WR;
  wire sent_pre = bus.cmd == CMD_PRE;
  wire sent_rda = sent_rd && bus.a10;
  wire [7:0] al8 = {5'h00, mode_al};
  wire [7:0] half_bl = mode_bl8 ? BL8_HALF : BL4_HALF;
  wire [7:0] rl = al8 + {5'h00, mode_cl};
  // the internal precharge never starts before two clocks past the last prefetch
  wire [7:0] rtp_rp_min = PF_GAP_CYC + TRP_CYC;
  wire [7:0] rtp_rp = (RTP_RP_CYC > rtp_rp_min) ? RTP_RP_CYC : rtp_rp_min;
  wire [7:0] act_gap = al8 + half_bl - PF_GAP_CYC + rtp_rp;

  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_bank
      wire sel = bus.bank == 3'(b);
      rapt_cnt u_act (
        .pclk(pclk),
        .presetn(presetn),
        .load((sent_rda || sent_pre) && sel),
        .value(sent_rda ? act_gap : TRP_CYC),
        .done(act_ok[b])
      );
      rapt_cnt u_ras (
        .pclk(pclk),
        .presetn(presetn),
        .load(sent_act && sel),
        .value(TRAS_CYC),
        .done(ras_ok[b])
      );
    end
  endgenerate

  // spacings after a read with auto precharge, any bank
  rapt_cnt u_rd (
    .pclk(pclk),
    .presetn(presetn),
    .load(sent_rda),
    .value(half_bl),
    .done(rd_ok)
  );
  rapt_cnt u_wr (
    .pclk(pclk),
    .presetn(presetn),
    .load(sent_rda),
    .value(half_bl + WR_EXTRA),
    .done(wr_ok)
  );
  rapt_cnt u_pa (
    .pclk(pclk),
    .presetn(presetn),
    .load(sent_rda),
    .value(PA_GAP_CYC),
    .done(pa_ok)
  );
  // read capture one edge after first data, write drive at RL minus one
  rapt_cnt u_cap (
    .pclk(pclk),
    .presetn(presetn),
    .load(sent_rd),
    .value(rl + 8'h01),
    .done(cap_ok)
  );
  rapt_cnt u_wrd (
    .pclk(pclk),
    .presetn(presetn),
    .load(sent_wr),
    .value(rl - 8'h01),
    .done(wrd_ok)
  );

  // issue gate
  wire pre_ok = ras_ok[bank_q] && act_ok[bank_q] && pa_ok;
  wire legal = (op_q == CMD_ACT) ? (act_ok[bank_q] && pa_ok)
    : (op_q == CMD_PRE) ? pre_ok
    : (op_q == CMD_RD) ? rd_ok
    : (op_q == CMD_WR) ? wr_ok
    : 1'b1;
  wire issue = busy && legal;

  // apb answer, one wait state, more while a command write finds busy set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= acc && !stall;
      pslverr <= acc && !stall && !(hit_cmd || hit_stat || hit_mode);
      if (acc)
        prdata <= rd_mux;
    end
  end

  // registers and command issue
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_al <= AL_RST;
      mode_cl <= CL_RST;
      mode_bl8 <= BL8_RST;
      busy <= 1'b0;
      op_q <= CMD_NOP;
      bank_q <= 3'h0;
      a10_q <= 1'b0;
      col_q <= 3'h0;
      wdata_q <= 16'h0000;
    end
    else
    begin
      if (mode_wr)
      begin
        mode_al <= pwdata[MODE_AL_LSB +: 3];
        mode_cl <= pwdata[MODE_CL_LSB +: 3];
        mode_bl8 <= pwdata[MODE_BL8_BIT];
      end
      if (cmd_wr)
      begin
        busy <= 1'b1;
        op_q <= rapt_cmd_t'(pwdata[CMD_OP_LSB +: 3]);
        bank_q <= pwdata[CMD_BANK_LSB +: 3];
        a10_q <= pwdata[CMD_A10_BIT];
        col_q <= pwdata[CMD_COL_LSB +: 3];
        wdata_q <= pwdata[CMD_WDATA_LSB +: 16];
      end
      else if (issue)
        busy <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus.cmd <= CMD_NOP;
      bus.bank <= 3'h0;
      bus.a10 <= 1'b0;
      bus.col <= 3'h0;
    end
    else
    begin
      bus.cmd <= issue ? op_q : CMD_NOP;
      bus.bank <= bank_q;
      bus.a10 <= a10_q;
      bus.col <= col_q;
    end
  end

  // read capture; a new result wins over a status read clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_pend <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 16'h0000;
    end
    else
    begin
      cap_pend <= sent_rd || (cap_pend && !cap_ok);
      rvalid <= (cap_pend && cap_ok) || (rvalid && !stat_rd);
      if (cap_pend && cap_ok)
        rdata <= bus.dq_bus;
    end
  end

  // write data drive, one word a clock for BL/2 clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_pend <= 1'b0;
      wr_data <= 16'h0000;
      wbeat <= 4'h0;
      bus.dq_ctl <= 16'h0000;
      bus.dq_ctl_oe_n <= 1'b1;
    end
    else
    begin
      wr_pend <= sent_wr || (wr_pend && !wrd_ok);
      if (sent_wr)
        wr_data <= wdata_q;
      if (wr_pend && wrd_ok)
      begin
        wbeat <= 4'h1;
        bus.dq_ctl <= wr_data;
        bus.dq_ctl_oe_n <= 1'b0;
      end
      else if (wbeat != 4'h0 && wbeat != half_bl[3:0])
      begin
        wbeat <= wbeat + 4'h1;
        bus.dq_ctl <= wr_data + {12'h000, wbeat};
      end
      else
      begin
        wbeat <= 4'h0;
        bus.dq_ctl_oe_n <= 1'b1;
      end
    end
  end
endmodule // rapt_ctl
`default_nettype wire

// ---- bench/rapt_checker.sv ----
// assertions on the link between controller and device ends
`timescale 1ns/1ns
`default_nettype none
module rapt_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link signals
  input wire rapt_pkg::rapt_cmd_t cmd,
  input wire logic [2:0] bank,
  input wire logic a10,
  input wire logic dq_dev_oe_n,
  input wire logic ldqs,
  input wire logic udqs,
  input wire logic dqs_oe_n,
  // mode and bank state
  input wire logic [2:0] mode_al,
  input wire logic [2:0] mode_cl,
  input wire logic mode_bl8,
  input wire logic [7:0] bank_open,
  input wire logic [7:0] bank_closing
);
  import rapt_pkg::*;
  logic [15:0] rd_hist;
  wire logic rda;
  wire logic [3:0] rd_lat;
  wire logic rd_due;
  wire logic rd_win;
  assign rda = (cmd == CMD_RD) && a10;
  assign rd_lat = 4'(mode_al) + 4'(mode_cl);
  assign rd_due = rd_hist[rd_lat];
  assign rd_win = |((rd_hist >> rd_lat) & (mode_bl8 ? 16'h000F : 16'h0003));
  // history of read commands, bit k set k+1 edges after the command
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_hist <= 16'h0000;
    else
      rd_hist <= {rd_hist[14:0], cmd == CMD_RD};
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rda_close_bl4: assert property (
    rda && !mode_bl8 && mode_al == 3'h0 && bank_open[bank] && !bank_closing[bank]
    |-> ##2 !bank_closing[$past(bank, 2)] ##1 bank_closing[$past(bank, 3)])
    else $error("auto precharge start wrong for burst of four");
  a_rda_close_bl8: assert property (
    rda && mode_bl8 && mode_al == 3'h0 && bank_open[bank] && !bank_closing[bank]
    |-> ##4 !bank_closing[$past(bank, 4)] ##1 bank_closing[$past(bank, 5)])
    else $error("auto precharge start wrong for burst of eight");
  a_close_one_cycle: assert property (
    (bank_closing & $past(bank_closing)) == 8'h00)
    else $error("precharge lasted longer than one clock");
  a_read_latency: assert property (rd_due |-> !dq_dev_oe_n)
    else $error("read data missing at read latency");
  a_dq_window: assert property (!dq_dev_oe_n |-> rd_win)
    else $error("device drives data outside a read burst");
  a_strobe_pair: assert property (
    !dq_dev_oe_n |-> (udqs == ldqs) && !dqs_oe_n && (ldqs != $past(ldqs)))
    else $error("byte strobes not toggling together with data");
  a_read_keeps_open: assert property (
    cmd == CMD_RD && !a10 && bank_open[bank] |-> ##2 bank_open[$past(bank, 2)])
    else $error("plain read closed the row");
  a_pre_closes: assert property (
    cmd == CMD_PRE && bank_open[bank] && !bank_closing[bank]
    |=> bank_closing[$past(bank)] && !bank_open[$past(bank)])
    else $error("explicit precharge did not close the row");
  a_rda_gap_bl4: assert property (
    rda && !mode_bl8 |=> (cmd != CMD_RD && cmd != CMD_WR) ##1 (cmd != CMD_WR) [*2])
    else $error("command too soon after auto precharge read");
  a_rda_gap_bl8: assert property (
    rda && mode_bl8 |=> (cmd != CMD_RD && cmd != CMD_WR) [*3] ##1 (cmd != CMD_WR) [*2])
    else $error("command too soon after long auto precharge read");
  c_rda_bl8: cover property (rda && mode_bl8);
  c_read_due: cover property (rd_due);
  c_pre: cover property (cmd == CMD_PRE);
endmodule // rapt_checker
`default_nettype wire

// ---- bench/read_auto_precharge_timing_bench.sv ----
// self-checking bench for the auto precharge timing link
`timescale 1ns/1ns
`default_nettype none
module read_auto_precharge_timing_bench;
  import rapt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] mode_al;
  logic [2:0] mode_cl;
  logic mode_bl8;
  logic [7:0] bank_open;
  logic [7:0] bank_closing;
  logic timing_err;
  logic [31:0] rd;
  logic err;
  int err_count = 0;
  int checks_done = 0;
  rapt_if link_if();
  always #50 pclk = ~pclk;
  rapt_ctl u_rapt_ctl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_al(mode_al), .mode_cl(mode_cl), .mode_bl8(mode_bl8),
    .bus(link_if.ctl));
  rapt_dev u_rapt_dev (.pclk(pclk), .presetn(presetn), .mode_al(mode_al), .mode_cl(mode_cl),
    .mode_bl8(mode_bl8), .bus(link_if.dev), .bank_open(bank_open),
    .bank_closing(bank_closing), .timing_err(timing_err));
  rapt_checker u_checker (.pclk(pclk), .presetn(presetn), .cmd(link_if.cmd),
    .bank(link_if.bank), .a10(link_if.a10), .dq_dev_oe_n(link_if.dq_dev_oe_n),
    .ldqs(link_if.ldqs), .udqs(link_if.udqs), .dqs_oe_n(link_if.dqs_oe_n),
    .mode_al(mode_al), .mode_cl(mode_cl), .mode_bl8(mode_bl8), .bank_open(bank_open),
    .bank_closing(bank_closing));
  task complete_run;
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task issue(input rapt_cmd_t op, input logic [2:0] b, input logic a, input logic [2:0] c,
    input logic [15:0] d);
    apb(ADDR_CMD, 1'b1, {d, 6'h00, c, a, b, op});
  endtask
  task wait_rvalid;
    do
      apb(ADDR_STAT, 1'b0, 32'h00000000);
    while (rd[STAT_RVALID_BIT] !== 1'b1);
  endtask
  function automatic logic [31:0] mode_word(logic [2:0] al, logic [2:0] cl, logic bl8);
    return (32'(al) << MODE_AL_LSB) | (32'(cl) << MODE_CL_LSB) | (32'(bl8) << MODE_BL8_BIT);
  endfunction
  initial
  begin
    #3000000;
    err_count++;
    complete_run;
  end
  initial
  begin
    logic [31:0] seed;
    logic [2:0] al;
    logic [2:0] cl;
    logic [2:0] b;
    logic [2:0] c;
    logic [15:0] d;
    seed = $urandom(47875);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(ADDR_MODE, 1'b0, 32'h00000000);
    check(rd, mode_word(AL_RST, CL_RST, BL8_RST));
    apb(ADDR_STAT, 1'b0, 32'h00000000);
    check(rd, 32'h00000000);
    apb(8'h0C, 1'b0, 32'h00000000);
    check({rd[31:1], err}, 32'h00000001);
    for (int i = 0; i < 8; i++)
    begin
      al = (i < 2) ? 3'h0 : 3'($urandom_range(0, 3));
      cl = 3'($urandom_range(2, 4));
      b = 3'(i);
      c = 3'($urandom);
      d = 16'($urandom);
      apb(ADDR_MODE, 1'b1, mode_word(al, cl, 1'(i)));
      apb(ADDR_MODE, 1'b0, 32'h00000000);
      check(rd, mode_word(al, cl, 1'(i)));
      issue(CMD_NOP, b, 1'b0, 3'h0, 16'h0000);
      issue(CMD_ACT, b, 1'b0, 3'h0, 16'h0000);
      issue(CMD_WR, b, 1'b0, c, d);
      issue(CMD_RD, b, 1'b1, c, 16'h0000);
      issue(CMD_ACT, b + 3'h1, 1'b0, 3'h0, 16'h0000);
      wait_rvalid;
      check({16'h0000, rd[31:16]}, {16'h0000, d});
      apb(ADDR_STAT, 1'b0, 32'h00000000);
      check(32'(rd[STAT_RVALID_BIT]), 32'h00000000);
      check(32'(bank_open), 32'(8'h01 << (b + 3'h1)));
      issue(CMD_RD, b + 3'h1, 1'b0, c, 16'h0000);
      wait_rvalid;
      check(32'(bank_open), 32'(8'h01 << (b + 3'h1)));
      issue(CMD_PRE, b + 3'h1, 1'b0, 3'h0, 16'h0000);
      repeat (4) @(posedge pclk);
      check(32'(bank_open), 32'h00000000);
    end
    // reopen a bank right behind its auto precharge read; the controller holds it
    issue(CMD_ACT, 3'h0, 1'b0, 3'h0, 16'h0000);
    issue(CMD_RD, 3'h0, 1'b1, 3'h0, 16'h0000);
    issue(CMD_ACT, 3'h0, 1'b0, 3'h0, 16'h0000);
    issue(CMD_PRE, 3'h0, 1'b0, 3'h0, 16'h0000);
    repeat (4) @(posedge pclk);
    check(32'(bank_open), 32'h00000000);
    check(32'(timing_err), 32'h00000000);
    complete_run;
  end
endmodule // read_auto_precharge_timing_bench
`default_nettype wire
